// [design/uhlc_top.sv]
// Processor bus decode, transmitter, receiver and modem pins of the serial block
`timescale 1ns/1ps
`include "uhlc_params.svh"

module uhlc_top
	import uhlc_pkg::*;
#(
	parameter int DATA_W = 8
) (
	// Clock, reset, enable
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              ce_in,
	// Processor bus
	input  wire logic              cs_n_in,
	input  wire logic              rd_n_in,
	input  wire logic              wr_n_in,
	input  wire logic              cd_in,
	input  wire logic [DATA_W-1:0] data_in,
	output logic      [DATA_W-1:0] data_out,
	output logic                   data_oe_out,
	// Modem pins
	input  wire logic              dsr_n_in,
	output logic                   dtr_n_out,
	input  wire logic              cts_n_in,
	output logic                   rts_n_out,
	// Transmit side
	input  wire logic              transmit_bit_clock_in,
	output logic                   txd_out,
	output logic                   transmit_ready_out,
	output logic                   transmitter_drained_out,
	// Receive side
	input  wire logic              receive_bit_clock_in,
	input  wire logic              rxd_in,
	output logic                   receive_ready_out
);

	generate
		if (DATA_W != 8) begin : g_width_check
			$error("uhlc_top supports an 8-bit data port only");
		end
	endgenerate

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [14:0]     pin_meta_q;
	logic [14:0]     pin_sync_q;
	logic            rd_p_q;
	logic            wr_p_q;
	logic            txc_p_q;
	logic            cs_s;
	logic            rd_s;
	logic            wr_s;
	logic            cd_s;
	logic            dsr_s;
	logic            cts_s;
	logic            txc_s;
	logic [7:0]      data_s;

	// Strobes, clock and data are all asynchronous to clk_in
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_meta_q <= 15'h7fff;
			pin_sync_q <= 15'h7fff;
			rd_p_q     <= 1'b1;
			wr_p_q     <= 1'b1;
			txc_p_q    <= 1'b1;
		end else if (ce_in) begin
			pin_meta_q <= {transmit_bit_clock_in, cts_n_in, dsr_n_in, cd_in,
				wr_n_in, rd_n_in, cs_n_in, data_in};  // [RL24]
			pin_sync_q <= pin_meta_q;
			rd_p_q     <= rd_s;
			wr_p_q     <= wr_s;
			txc_p_q    <= txc_s;
		end
	end

	assign data_s = pin_sync_q[7:0];
	assign cs_s   = pin_sync_q[8];
	assign rd_s   = pin_sync_q[9];
	assign wr_s   = pin_sync_q[10];
	assign cd_s   = pin_sync_q[11];
	assign dsr_s  = pin_sync_q[12];
	assign cts_s  = pin_sync_q[13];
	assign txc_s  = pin_sync_q[14];

	// ************************************************************
	// Bus decode
	// ************************************************************
	logic       sel_q;
	logic       cdl_q;
	logic [7:0] wdata_q;
	logic       wr_rise;
	logic       rd_rise;
	logic       data_wr;
	logic       ctl_wr;
	logic       data_rd_done;

	// Select and address are held from the last cycle the strobe was low,
	// since the cycle may have ended by the time the trailing edge is seen
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sel_q   <= 1'b0;
			cdl_q   <= 1'b0;
			wdata_q <= 8'h00;
		end else if (ce_in) begin
			if (!rd_s || !wr_s) begin
				sel_q <= !cs_s;
				cdl_q <= cd_s;
			end
			if (!wr_s) begin
				wdata_q <= data_s;
			end
		end
	end

	assign wr_rise      = wr_s && !wr_p_q;
	assign rd_rise      = rd_s && !rd_p_q;
	assign data_wr      = wr_rise && sel_q && !cdl_q;  // [RL1] [RL17]
	assign ctl_wr       = wr_rise && sel_q && cdl_q;
	assign data_rd_done = rd_rise && sel_q && !cdl_q;

	// ************************************************************
	// Control words
	// ************************************************************
	uhlc_ctl_state_t ctl_state_q;
	logic [7:0]      mode_q;
	logic [7:0]      cmd_q;
	logic [7:0]      sync_char_q;
	logic            sync_mode;
	logic            transmit_enable_bit;
	logic            rxen;
	logic [3:0]      char_len;
	logic [5:0]      tx_m1;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctl_state_q <= UHLC_ST_MODE;  // [RL5]
			mode_q      <= `UHLC_RST_MODE;
			cmd_q       <= `UHLC_RST_CMD;
			sync_char_q <= `UHLC_RST_SYNC;
		end else if (ce_in && ctl_wr) begin
			case (ctl_state_q)
				UHLC_ST_MODE: begin
					mode_q <= wdata_q;
					if (wdata_q[1:0] == `UHLC_RATE_SYNC) begin
						ctl_state_q <= UHLC_ST_SYNC;
					end else begin
						ctl_state_q <= UHLC_ST_CMD;
					end
				end
				UHLC_ST_SYNC: begin
					sync_char_q <= wdata_q;
					ctl_state_q <= UHLC_ST_CMD;
				end
				UHLC_ST_CMD: begin
					if (wdata_q[`UHLC_CMD_IRESET]) begin
						cmd_q       <= `UHLC_RST_CMD;  // [RL5]
						ctl_state_q <= UHLC_ST_MODE;
					end else begin
						cmd_q <= wdata_q;
					end
				end
				default: begin
					ctl_state_q <= UHLC_ST_MODE;
				end
			endcase
		end
	end

	assign sync_mode = (mode_q[1:0] == `UHLC_RATE_SYNC);
	assign transmit_enable_bit      = cmd_q[`UHLC_CMD_TRANSMIT_ENABLE_BIT];
	assign rxen      = cmd_q[`UHLC_CMD_RXEN];
	assign char_len  = {2'b00, mode_q[3:2]} + `UHLC_LEN_BASE;
	assign tx_m1     = uhlc_div_m1(mode_q[1:0]);  // [RL12]

	// ************************************************************
	// Transmitter
	// ************************************************************
	logic [5:0] presc_q;
	logic       tx_fall;
	logic       tx_tick;
	logic [7:0] buf_q;
	logic       buf_full_q;
	logic       commit_q;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_left_q;
	logic       fill_q;
	logic       txd_q;
	logic       tx_allow;
	logic       tx_go;
	logic       fill_ok;
	logic       tx_idle;
	logic [7:0] tx_src;
	logic [7:0] tx_dm;
	logic [9:0] tx_frame;
	logic [3:0] tx_total;

	assign tx_fall  = txc_p_q && !txc_s;  // [RL13]
	assign tx_tick  = tx_fall && (presc_q == tx_m1);
	assign tx_allow = transmit_enable_bit && !cts_s;  // [RL10]
	assign tx_go    = buf_full_q && (commit_q || tx_allow);  // [RL11]
	assign fill_ok  = sync_mode && tx_allow;  // [RL19]
	assign tx_idle  = (tx_left_q == 4'h0);

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			presc_q <= 6'h00;
		end else if (ce_in && tx_fall) begin
			presc_q <= (presc_q == tx_m1) ? 6'h00 : presc_q + 6'h01;  // [RL12]
		end
	end

	// Bit positions past the character length are filled with mark
	always_comb begin
		tx_src = tx_go ? buf_q : sync_char_q;
		for (int i = 0; i < 8; i++) begin
			tx_dm[i] = (i < int'(char_len)) ? tx_src[i] : 1'b1;
		end
		if (sync_mode) begin
			tx_frame = {2'b11, tx_dm};
			tx_total = char_len;
		end else begin
			tx_frame = {1'b1, tx_dm, 1'b0};
			tx_total = char_len + 4'h2;
		end
	end

	// A write landing on the same tick as a start wins: the old byte goes
	// out and the new one stays pending
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			buf_q      <= 8'h00;
			buf_full_q <= 1'b0;
			commit_q   <= 1'b0;
		end else if (ce_in) begin
			if (data_wr) begin
				buf_q      <= wdata_q;
				buf_full_q <= 1'b1;  // [RL17]
				commit_q   <= transmit_enable_bit;  // [RL11]
			end else if (tx_tick && tx_idle && tx_go) begin
				buf_full_q <= 1'b0;
				commit_q   <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_sh_q   <= 10'h3ff;
			tx_left_q <= 4'h0;
			fill_q    <= 1'b0;
			txd_q     <= 1'b1;  // [RL14]
		end else if (ce_in && tx_tick) begin
			if (!tx_idle) begin
				txd_q     <= tx_sh_q[0];  // [RL11]
				tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
				tx_left_q <= tx_left_q - 4'h1;
			end else if (tx_go || fill_ok) begin
				txd_q     <= tx_frame[0];
				tx_sh_q   <= {1'b1, tx_frame[9:1]};
				tx_left_q <= tx_total - 4'h1;
				fill_q    <= !tx_go;  // [RL19]
			end else begin
				txd_q  <= 1'b1;  // [RL14]
				fill_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Receive crossing into the master domain
	// ************************************************************
	logic [7:0] rx_hold_q;
	logic       rx_tog_q;
	logic [2:0] rx_tog_sync_q;
	logic [7:0] rx_buf_q;
	logic       rx_rdy_q;
	logic       rx_new;

	// The held byte is stable for a whole character; the master clock
	// being far above the bit rate lets three stages catch it in time
	assign rx_new = rx_tog_sync_q[2] ^ rx_tog_sync_q[1];  // [RL4]

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rx_tog_sync_q <= 3'h0;
			rx_buf_q      <= 8'h00;
			rx_rdy_q      <= 1'b0;
		end else if (ce_in) begin
			rx_tog_sync_q <= {rx_tog_sync_q[1:0], rx_tog_q};
			if (rx_new) begin
				rx_buf_q <= rx_hold_q;  // [RL22]
			end
			if (!rxen) begin
				rx_rdy_q <= 1'b0;  // [RL23]
			end else if (rx_new) begin
				rx_rdy_q <= 1'b1;
			end else if (data_rd_done) begin
				rx_rdy_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Status and pin outputs
	// ************************************************************
	logic [7:0] status_d;
	logic [7:0] data_q;
	logic       data_oe_q;
	logic       dtr_n_q;
	logic       rts_n_q;
	logic       transmit_ready_pin_q;
	logic       drained_q;

	always_comb begin
		status_d                    = 8'h00;
		status_d[`UHLC_STS_TRANSMIT_READY]   = !buf_full_q;  // [RL16]
		status_d[`UHLC_STS_RECEIVE_READY]   = rx_rdy_q;
		status_d[`UHLC_STS_DRAINED] = drained_q;
		status_d[`UHLC_STS_DSR]     = !dsr_s;  // [RL7]
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			data_q      <= 8'h00;
			data_oe_q   <= 1'b0;
			dtr_n_q     <= 1'b1;
			rts_n_q     <= 1'b1;
			transmit_ready_pin_q <= 1'b0;
			drained_q   <= 1'b1;
		end else if (ce_in) begin
			data_oe_q   <= !cs_s && !rd_s && wr_s;  // [RL2] [RL3]
			data_q      <= cd_s ? status_d : rx_buf_q;  // [RL1]
			dtr_n_q     <= !cmd_q[`UHLC_CMD_DTR];  // [RL8]
			rts_n_q     <= !cmd_q[`UHLC_CMD_RTS];  // [RL9]
			transmit_ready_pin_q <= !buf_full_q && tx_allow;  // [RL15]
			if (data_wr && transmit_enable_bit) begin
				drained_q <= 1'b0;  // [RL18]
			end else begin
				drained_q <= !(buf_full_q && commit_q) && (tx_idle || fill_q);
			end
		end
	end

	assign data_out                = data_q;
	assign data_oe_out             = data_oe_q;
	assign dtr_n_out               = dtr_n_q;
	assign rts_n_out               = rts_n_q;
	assign txd_out                 = txd_q;
	assign transmit_ready_out      = transmit_ready_pin_q;
	assign transmitter_drained_out = drained_q;
	assign receive_ready_out       = rx_rdy_q;

	// ************************************************************
	// Receiver, in the receive bit clock domain
	// ************************************************************
	logic [6:0] rcfg_meta_q;
	logic [6:0] rcfg_sync_q;
	logic       r_ce;
	logic       r_en;
	logic       r_sync;
	logic       r_x1;
	logic       r_rxd;
	logic [3:0] r_len;
	logic [5:0] r_m1;
	logic       r_act_q;
	logic [5:0] r_cnt_q;
	logic [3:0] r_bits_q;
	logic [7:0] r_sh_q;
	logic [7:0] r_sh_next;

	always_ff @(posedge receive_bit_clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rcfg_meta_q <= 7'h40;
			rcfg_sync_q <= 7'h40;
		end else begin
			rcfg_meta_q <= {rxd_in, ce_in, rxen, mode_q[3:0]};
			rcfg_sync_q <= rcfg_meta_q;
		end
	end

	assign r_rxd     = rcfg_sync_q[6];
	assign r_ce      = rcfg_sync_q[5];
	assign r_en      = rcfg_sync_q[4];
	assign r_sync    = (rcfg_sync_q[1:0] == `UHLC_RATE_SYNC);
	assign r_x1      = (rcfg_sync_q[1:0] == `UHLC_RATE_X1);
	assign r_len     = {2'b00, rcfg_sync_q[3:2]} + `UHLC_LEN_BASE;
	assign r_m1      = uhlc_div_m1(rcfg_sync_q[1:0]);  // [RL20]
	assign r_sh_next = {r_rxd, r_sh_q[7:1]};

	// Sync mode has no character framing here: bits are grouped from the
	// moment the receiver is enabled
	always_ff @(posedge receive_bit_clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			r_act_q   <= 1'b0;
			r_cnt_q   <= 6'h00;
			r_bits_q  <= 4'h0;
			r_sh_q    <= 8'h00;
			rx_hold_q <= 8'h00;
			rx_tog_q  <= 1'b0;
		end else if (r_ce) begin
			if (!r_en) begin
				r_act_q  <= 1'b0;
				r_bits_q <= 4'h0;
			end else if (!r_act_q) begin
				if (r_sync) begin
					r_act_q  <= 1'b1;
					r_bits_q <= 4'h1;
					r_cnt_q  <= 6'h00;
				end else if (!r_rxd) begin
					r_act_q  <= 1'b1;
					r_bits_q <= r_x1 ? 4'h1 : 4'h0;
					r_cnt_q  <= r_x1 ? 6'h00 : {1'b0, r_m1[5:1]};
				end
			end else if (r_cnt_q != 6'h00) begin
				r_cnt_q <= r_cnt_q - 6'h01;  // [RL20]
			end else begin
				r_cnt_q <= r_m1;
				if (r_bits_q == 4'h0) begin
					// False start: line back at mark by mid start bit
					if (r_rxd) begin
						r_act_q <= 1'b0;
					end else begin
						r_bits_q <= 4'h1;
					end
				end else if (r_bits_q <= r_len) begin
					r_sh_q <= r_sh_next;  // [RL21]
					if (r_sync && r_bits_q == r_len) begin
						rx_hold_q <= r_sh_next >> (4'h8 - r_len);  // [RL22]
						rx_tog_q  <= !rx_tog_q;
						r_bits_q  <= 4'h1;
					end else begin
						r_bits_q <= r_bits_q + 4'h1;
					end
				end else begin
					rx_hold_q <= r_sh_q >> (4'h8 - r_len);  // [RL22]
					rx_tog_q  <= !rx_tog_q;
					r_act_q   <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in || !ce_in);

	sequence s_data_wr;
		data_wr && transmit_enable_bit;
	endsequence

	sequence s_status_rd;
		!cs_s && !rd_s && wr_s && cd_s;
	endsequence

	a_bus_float_cs: assert property (cs_s |=> !data_oe_out)  // [RL2]
		else $error("bus driven while deselected");
	a_bus_float_idle: assert property (rd_s && wr_s |=> !data_oe_out)  // [RL2]
		else $error("bus driven with no read strobe");
	a_status_read: assert property (s_status_rd |=> data_oe_out && data_out == $past(status_d))  // [RL1]
		else $error("status read returned wrong byte");
	a_write_loads: assert property (data_wr |=> buf_full_q && buf_q == $past(wdata_q))  // [RL17]
		else $error("data write did not fill transmit buffer");
	a_ready_pin: assert property (transmit_ready_out |-> $past(!buf_full_q && transmit_enable_bit && !cts_s))  // [RL15]
		else $error("transmit ready pin set without its conditions");
	a_dtr_follow: assert property (##1 dtr_n_out == !$past(cmd_q[`UHLC_CMD_DTR]))  // [RL8]
		else $error("terminal ready pin does not follow command");
	a_rts_follow: assert property (##1 rts_n_out == !$past(cmd_q[`UHLC_CMD_RTS]))  // [RL9]
		else $error("request to send pin does not follow command");
	a_idle_cmd: assert property (ctl_state_q == UHLC_ST_MODE |-> cmd_q == `UHLC_RST_CMD)  // [RL5]
		else $error("command active before programming");
	a_no_start: assert property (tx_tick && tx_idle && buf_full_q && !commit_q && !tx_allow
		&& !data_wr |=> buf_full_q && tx_idle)  // [RL10]
		else $error("character started while transmitter disabled");
	a_finish_char: assert property (tx_tick && !tx_idle && !tx_allow
		|=> tx_left_q == $past(tx_left_q) - 4'h1)  // [RL11]
		else $error("character cut short by disable");
	a_mark_idle: assert property (tx_tick && tx_idle && !tx_go && !fill_ok |=> txd_out)  // [RL14]
		else $error("line not at mark while idle");
	a_drained_low: assert property (s_data_wr |=> !transmitter_drained_out)  // [RL18]
		else $error("drained stayed high after enabled write");
	a_rx_masked: assert property (!rxen |=> !receive_ready_out)  // [RL23]
		else $error("receive ready shown while receiver disabled");

endmodule : uhlc_top

// [design/uhlc_params.svh]
// Field positions, reset values and clock factors of the serial interface block
// Operation
// [RL1] Selected read/write routes data buffers or status
// [RL2] Deselected or no strobe: bus floats, strobes ignored
// [RL3] Eight-bit three-state data port
// [RL4] Master clock well above serial bit rate
// [RL5] Reset idles until control words written
// [RL6] Reset held at least six master clocks
// [RL7] Inverted data-set-ready readable in status
// [RL8] Command bit drives terminal-ready pin low
// [RL9] Command bit drives request-to-send pin low
// [RL10] Transmit only with clear-to-send low, enabled
// [RL11] Disable mid-send: finish written characters first
// [RL12] Transmit rate: clock, or 1/16, 1/64
// [RL13] Transmit bits shift on falling clock edge
// [RL14] Line holds mark when idle or reset
// [RL15] Ready pin: buffer empty, clear-to-send, enabled
// [RL16] Ready status bit: buffer empty only
// [RL17] Write strobe trailing edge clears ready
// [RL18] Drained high when empty, low on write
// [RL19] Sync mode sends fillers, drained stays high
// [RL20] Receive rate: clock, or 1/16, 1/64
// [RL21] Receive line sampled on rising clock edge
// [RL22] Assemble characters into receive data buffer
// [RL23] Receive ready masked while receiver disabled
// [RL24] Strobes and bit clocks synchronised before use; the receive bit clock clocks the receiver directly
`ifndef UHLC_PARAMS_SVH
`define UHLC_PARAMS_SVH

// Mode word fields
`define UHLC_MODE_RATE_LSB 0
`define UHLC_MODE_LEN_LSB  2
`define UHLC_RATE_SYNC     2'h0
`define UHLC_RATE_X1       2'h1
`define UHLC_RATE_X16      2'h2
`define UHLC_RATE_X64      2'h3
`define UHLC_LEN_BASE      4'h5

// Command word bits
`define UHLC_CMD_TRANSMIT_ENABLE_BIT      0
`define UHLC_CMD_DTR       1
`define UHLC_CMD_RXEN      2
`define UHLC_CMD_RTS       5
`define UHLC_CMD_IRESET    6

// Status byte bits
`define UHLC_STS_TRANSMIT_READY     0
`define UHLC_STS_RECEIVE_READY     1
`define UHLC_STS_DRAINED   2
`define UHLC_STS_DSR       7

// Clock divide counts, minus one
`define UHLC_DIV1_M1       6'h00
`define UHLC_DIV16_M1      6'h0f
`define UHLC_DIV64_M1      6'h3f

// Reset values
`define UHLC_RST_MODE      8'h00
`define UHLC_RST_CMD       8'h00
`define UHLC_RST_SYNC      8'h00

`endif

// [design/uhlc_pkg.sv]
// Types and helpers of the serial interface block
package uhlc_pkg;
`include "uhlc_params.svh"

	typedef enum logic [2:0] {
		UHLC_ST_MODE = 3'b001,
		UHLC_ST_SYNC = 3'b010,
		UHLC_ST_CMD  = 3'b100
	} uhlc_ctl_state_t;

	function automatic logic [5:0] uhlc_div_m1(input logic [1:0] rate);
		case (rate)
			`UHLC_RATE_X16: uhlc_div_m1 = `UHLC_DIV16_M1;
			`UHLC_RATE_X64: uhlc_div_m1 = `UHLC_DIV64_M1;
			default:        uhlc_div_m1 = `UHLC_DIV1_M1;
		endcase
	endfunction : uhlc_div_m1

endpackage : uhlc_pkg

// [testbench/uhlc_line_model.sv]
// Far end of the serial line: bit clocks, receive data source, transmit data capture
`timescale 1ns/1ps

module uhlc_line_model (
	// Serial line
	input  wire logic txd_in,
	output logic      transmit_bit_clock_out,
	output logic      receive_bit_clock_out,
	output logic      rxd_out
);
	initial begin
		transmit_bit_clock_out = 1'b1;
		receive_bit_clock_out = 1'b1;
		rxd_out = 1'b1;
	end

	// ****************************************
	// Transmit clock, still outside frames
	// ****************************************
	// One period of 160 ns, twenty master clocks; only a capture runs it
	task automatic tick();
		#80 transmit_bit_clock_out = 1'b0;
		#80 transmit_bit_clock_out = 1'b1;
	endtask : tick

	// Sample on a rising edge, well after the falling edge that shifts;
	// n is the clock factor, so samples stand one bit time apart
	task automatic capture(input int n, output logic found, output logic [7:0] val,
		output logic stop);
		int i;
		found = 1'b0;
		val = 8'h00;
		stop = 1'b0;
		for (i = 0; i < 12 && !found; i++) begin
			repeat (n) tick();
			found = (txd_in === 1'b0);
		end
		if (found) begin
			for (i = 0; i < 8; i++) begin
				repeat (n) tick();
				val[i] = txd_in;
			end
			repeat (n) tick();
			stop = txd_in;
			// Extra bit times let the stop bit end; line must rest at mark
			repeat (2 * n) tick();
			stop = stop & txd_in;
		end
	endtask : capture

	// ****************************************
	// Receive frame, clock runs only with it
	// ****************************************
	// Data changes on the falling edge so the rising edge sees it settled
	// n receive clocks stand in each bit
	task automatic send(input int n, input logic [7:0] val);
		logic [18:0] bits;
		int          i;
		bits = {6'h3f, 1'b1, val, 1'b0, 3'h7};
		#5;
		for (i = 0; i < 19; i++) begin
			rxd_out = bits[i];
			repeat (n) begin
				receive_bit_clock_out = 1'b0;
				#24 receive_bit_clock_out = 1'b1;
				#24;
			end
		end
	endtask : send
endmodule : uhlc_line_model

// [testbench/usart_host_and_line_control_tb.sv]
// Self-checking bench of the serial block: bus decode, modem pins, transmit and receive
`timescale 1ns/1ps

module usart_host_and_line_control_tb;
	import uhlc_pkg::*;

	logic       clk_in, sys_rst_in, cs_n_in, rd_n_in, wr_n_in, cd_in;
	logic       dsr_n_in, cts_n_in, data_oe_out, dtr_n_out, rts_n_out, txd_out;
	logic       transmit_ready_out, transmitter_drained_out, receive_ready_out;
	logic       tbc, rbc, rxd;
	logic [7:0] host_q, data_in, data_out, pins, d;
	logic       oe, found, stop;
	int         errors, cmp_count, i;

	// Bus wire: device drives when enabled, otherwise the host
	assign data_in = data_oe_out ? data_out : host_q;
	assign pins = {1'b0, data_oe_out, dtr_n_out, rts_n_out, txd_out,
		transmit_ready_out, transmitter_drained_out, receive_ready_out};

	uhlc_top dut_u (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
		.cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .cd_in(cd_in),
		.data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
		.dsr_n_in(dsr_n_in), .dtr_n_out(dtr_n_out), .cts_n_in(cts_n_in),
		.rts_n_out(rts_n_out), .transmit_bit_clock_in(tbc), .txd_out(txd_out),
		.transmit_ready_out(transmit_ready_out),
		.transmitter_drained_out(transmitter_drained_out),
		.receive_bit_clock_in(rbc), .rxd_in(rxd), .receive_ready_out(receive_ready_out)
	);

	uhlc_line_model line_u (
		.txd_in(txd_out), .transmit_bit_clock_out(tbc),
		.receive_bit_clock_out(rbc), .rxd_out(rxd)
	);

	always #4 clk_in = ~clk_in;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc

	// Strobe held 13 clocks, select 3 past the rise, then write recovery
	task automatic bus_wr(input logic c, input logic [7:0] v, input logic sel_n);
		@(posedge clk_in);
		cs_n_in <= sel_n;
		cd_in <= c;
		host_q <= v;
		wr_n_in <= 1'b0;
		cyc(13);
		wr_n_in <= 1'b1;
		cyc(3);
		cs_n_in <= 1'b1;
		cyc(6);
	endtask : bus_wr

	task automatic bus_rd(input logic c, input logic sel_n, output logic [7:0] v,
		output logic e);
		@(posedge clk_in);
		cs_n_in <= sel_n;
		cd_in <= c;
		rd_n_in <= 1'b0;
		cyc(13);
		v = data_out;
		e = data_oe_out;
		rd_n_in <= 1'b1;
		cs_n_in <= 1'b1;
		cyc(6);
	endtask : bus_rd

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_setup();
		chk("reset pins", pins, 8'h3a);
		bus_wr(1'b1, 8'h0d, 1'b0);
		bus_wr(1'b1, 8'h27, 1'b0);
		cyc(4);
		chk("enabled pins", pins, 8'h0e);
		bus_rd(1'b1, 1'b0, d, oe);
		chk("status dsr low", d, 8'h85);
		chk("status drive", {7'h00, oe}, 8'h01);
		@(posedge clk_in);
		dsr_n_in <= 1'b1;
		cyc(4);
		bus_rd(1'b1, 1'b0, d, oe);
		chk("status dsr high", d, 8'h05);
		bus_wr(1'b1, 8'h05, 1'b0);
		chk("modem pins off", pins, 8'h3e);
		bus_wr(1'b1, 8'h27, 1'b0);
	endtask : t_setup

	task automatic t_float();
		bus_rd(1'b1, 1'b1, d, oe);
		chk("deselected drive", {7'h00, oe}, 8'h00);
		bus_wr(1'b1, 8'h00, 1'b1);
		chk("deselected write", pins, 8'h0e);
	endtask : t_float

	task automatic t_tx_gate();
		bus_wr(1'b1, 8'h26, 1'b0);
		bus_wr(1'b0, 8'h3c, 1'b0);
		chk("ready pin off", {7'h00, transmit_ready_out}, 8'h00);
		line_u.capture(1, found, d, stop);
		chk("sent while off", {7'h00, found, txd_out}, 8'h01);
		@(posedge clk_in);
		cts_n_in <= 1'b1;
		bus_wr(1'b1, 8'h27, 1'b0);
		line_u.capture(1, found, d, stop);
		chk("sent while cts high", {7'h00, found, txd_out}, 8'h01);
		@(posedge clk_in);
		cts_n_in <= 1'b0;
		line_u.capture(1, found, d, stop);
		chk("char", d, 8'h3c);
		chk("stop", {7'h00, found, stop}, 8'h03);
		cyc(8);
		chk("idle pins", pins, 8'h0e);
	endtask : t_tx_gate

	task automatic t_tx_drain();
		bus_wr(1'b0, 8'ha6, 1'b0);
		chk("loaded pins", pins, 8'h08);
		bus_wr(1'b1, 8'h26, 1'b0);
		line_u.capture(1, found, d, stop);
		chk("char after disable", d, 8'ha6);
		cyc(8);
		chk("disabled pins", pins, 8'h0a);
		bus_rd(1'b1, 1'b0, d, oe);
		chk("ready status", d, 8'h05);
		bus_wr(1'b1, 8'h27, 1'b0);
	endtask : t_tx_drain

	task automatic t_rx();
		line_u.send(1, 8'hc5);
		for (i = 0; i < 100 && receive_ready_out !== 1'b1; i++) cyc(1);
		chk("rx ready", {7'h00, receive_ready_out}, 8'h01);
		bus_rd(1'b0, 1'b0, d, oe);
		chk("rx char", d, 8'hc5);
		chk("rx ready cleared", {7'h00, receive_ready_out}, 8'h00);
		bus_wr(1'b1, 8'h23, 1'b0);
		line_u.send(1, 8'h5a);
		cyc(40);
		chk("rx masked", {7'h00, receive_ready_out}, 8'h00);
	endtask : t_rx

	// Internal reset, then the same traffic at sixteen clocks a bit
	task automatic t_x16();
		bus_wr(1'b1, 8'h40, 1'b0);
		chk("internal reset pins", pins, 8'h3a);
		bus_wr(1'b1, 8'h0e, 1'b0);
		bus_wr(1'b1, 8'h27, 1'b0);
		bus_wr(1'b0, 8'h93, 1'b0);
		line_u.capture(16, found, d, stop);
		chk("x16 char", d, 8'h93);
		chk("x16 stop", {7'h00, found, stop}, 8'h03);
		line_u.send(16, 8'h6b);
		for (i = 0; i < 100 && receive_ready_out !== 1'b1; i++) cyc(1);
		chk("x16 rx ready", {7'h00, receive_ready_out}, 8'h01);
		bus_rd(1'b0, 1'b0, d, oe);
		chk("x16 rx char", d, 8'h6b);
	endtask : t_x16

	initial begin
		clk_in = 1'b0;
		sys_rst_in = 1'b1;
		cs_n_in = 1'b1;
		rd_n_in = 1'b1;
		wr_n_in = 1'b1;
		cd_in = 1'b0;
		host_q = 8'h00;
		dsr_n_in = 1'b0;
		cts_n_in = 1'b0;
		errors = 0;
		cmp_count = 0;
		// Held six clocks, the minimum the device asks for
		cyc(6);
		sys_rst_in <= 1'b0;
		cyc(4);
		t_setup();
		t_float();
		t_tx_gate();
		t_tx_drain();
		t_rx();
		t_x16();
		finish_test();
	end

	// Whole run is some 60 us; a hang is cut well past it
	initial begin
		#150000;
		errors++;
		finish_test();
	end
endmodule : usart_host_and_line_control_tb
